// [design/dram_card_addr_decode_strobe.sv]
`timescale 1ns/1ps
`default_nettype none
module dram_card_addr_decode_strobe
    import dram_card_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [23:0] bus_addr,
    input wire logic mem_read_status,
    input wire logic mem_write_status,
    input wire logic psync,
    input wire logic pstval_n,
    input wire logic pwr_n,
    input wire logic sixteen_req,
    input wire logic [7:0] board_base_switch,
    input wire logic size_jumper_a,
    input wire logic size_jumper_b,
    input wire logic bank_bit_jumper,
    output logic board_selected,
    output logic rdy,
    output logic sixteen_ack,
    output logic [7:0] mem_addr_lines,
    output logic [3:0] row_strobe_n,
    output logic [3:0] col_strobe_n,
    output logic row_col_sel,
    output logic refresh_cycle_flag
);

    typedef enum {
        ST_IDLE,
        ST_ROW,
        ST_SELECT,
        ST_COLUMN,
        ST_REF_ADDR,
        ST_REF_ROW,
        ST_PRECHARGE
    } seq_state_t;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    localparam int PIN_W = 41;

    logic [PIN_W-1:0] pin_vec;
    logic [PIN_W-1:0] sync1_reg;
    logic [PIN_W-1:0] sync2_reg;
    logic [23:0] s_addr;
    logic s_read;
    logic s_write;
    logic s_psync;
    logic s_pstval_n;
    logic s_pwr_n;
    logic s_wide;
    logic [7:0] s_switch;
    logic s_jumper_a;
    logic s_jumper_b;
    logic s_bank_jumper;

    assign pin_vec = {bus_addr, mem_read_status, mem_write_status, psync, pstval_n,
        pwr_n, sixteen_req, board_base_switch, size_jumper_a, size_jumper_b,
        bank_bit_jumper};

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= pin_vec;
            sync2_reg <= sync1_reg;
        end
    end

    assign {s_addr, s_read, s_write, s_psync, s_pstval_n, s_pwr_n, s_wide, s_switch,
        s_jumper_a, s_jumper_b, s_bank_jumper} = sync2_reg;

    // ==========================================================
    // Static configuration and address decode
    // ==========================================================
    mem_size_t size;
    logic hit;
    logic [7:0] row_live;
    logic [7:0] col_live;
    logic [3:0] mask_live;
    logic wide_live;
    logic wide_en;

    // Switches and jumpers are straps; software can only read back the switches and the size, not the bank bit jumper.
    always_comb
    begin
        if (s_jumper_a && s_jumper_b)
            size = SIZE_64K;
        else if (s_jumper_a)
            size = SIZE_128K;
        else
            size = SIZE_256K;
    end

    dram_addr_select addr_select (
        .bus_addr(s_addr),
        .board_base_switch(s_switch),
        .size(size),
        .bank_bit_jumper(s_bank_jumper),
        .wide_access(s_wide && wide_en),
        .board_hit(hit),
        .row_addr(row_live),
        .col_addr(col_live),
        .bank_mask(mask_live),
        .wide_ok(wide_live)
    );

    // ==========================================================
    // Control register
    // ==========================================================
    logic [31:0] ctrl_reg;
    logic apb_write;
    logic apb_access;
    logic refresh_en;

    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (addr == CTRL_OFFSET) || (addr == STATUS_OFFSET)
            || (addr == COUNT_OFFSET);
    endfunction

    assign apb_access = psel && penable;
    assign apb_write = apb_access && pwrite;
    assign refresh_en = ctrl_reg[CTRL_REFRESH_EN_BIT];
    assign wide_en = ctrl_reg[CTRL_WIDE_EN_BIT];

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            ctrl_reg <= CTRL_RESET;
        else if (apb_write && (paddr == CTRL_OFFSET))
            ctrl_reg <= pwdata & CTRL_RESET;
    end

    // ==========================================================
    // Bus cycle start and access capture
    // ==========================================================
    logic pstval_prev_reg;
    logic cycle_start;
    logic acc_pending_reg;
    logic acc_is_write_reg;
    logic acc_go;
    logic [7:0] row_reg;
    logic [7:0] col_reg;
    logic [3:0] bank_reg;
    seq_state_t state_reg;
    seq_state_t state_next;
    logic [2:0] phase_cnt_reg;
    logic phase_done;
    logic refresh_busy;
    logic access_done;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            pstval_prev_reg <= 1'b1;
        else
            pstval_prev_reg <= s_pstval_n;
    end

    assign cycle_start = s_psync && pstval_prev_reg && !s_pstval_n;
    // A write only reaches the array once the master says its data is valid.
    assign acc_go = acc_pending_reg && (!acc_is_write_reg || !s_pwr_n);
    assign refresh_busy = (state_reg == ST_REF_ADDR) || (state_reg == ST_REF_ROW)
        || refresh_cycle_flag;
    assign access_done = (state_reg == ST_COLUMN) && phase_done;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acc_pending_reg <= 1'b0;
            acc_is_write_reg <= 1'b0;
            row_reg <= 8'h00;
            col_reg <= 8'h00;
            bank_reg <= STROBES_NONE;
        end
        else if (cycle_start && hit && (s_read || s_write))
        begin
            acc_pending_reg <= 1'b1;
            acc_is_write_reg <= s_write && !s_read;
            row_reg <= row_live;
            col_reg <= col_live;
            bank_reg <= mask_live;
        end
        else if (access_done)
            acc_pending_reg <= 1'b0;
    end

    // ==========================================================
    // Refresh timer and request
    // ==========================================================
    logic [REFRESH_CNT_W-1:0] refresh_timer_reg;
    logic refresh_req_reg;
    logic refresh_start;
    logic [7:0] refresh_row_reg;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            refresh_timer_reg <= '0;
        else if (refresh_timer_reg == REFRESH_LAST)
            refresh_timer_reg <= '0;
        else
            refresh_timer_reg <= refresh_timer_reg + 1'b1;
    end

    // A refresh is never begun alongside a bus cycle start or an access.
    assign refresh_start = (state_reg == ST_IDLE) && refresh_req_reg && refresh_en
        && !acc_pending_reg && !s_psync && !cycle_start;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            refresh_req_reg <= 1'b0;
        else if (refresh_timer_reg == REFRESH_LAST)
            refresh_req_reg <= 1'b1;
        else if (refresh_start)
            refresh_req_reg <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            refresh_row_reg <= 8'h00;
        else if ((state_reg == ST_REF_ROW) && phase_done)
            refresh_row_reg <= refresh_row_reg + 1'b1;
    end

    // ==========================================================
    // Delay-tap sequencer
    // ==========================================================
    logic [2:0] phase_len;
    logic delay_stage_one;
    logic delay_stage_two;

    always_comb
    begin
        case (state_reg)
            ST_ROW: phase_len = ROW_PHASE_CYCLES;
            ST_SELECT: phase_len = SELECT_PHASE_CYCLES;
            ST_COLUMN: phase_len = COLUMN_PHASE_CYCLES;
            ST_REF_ADDR: phase_len = REF_ADDR_CYCLES;
            ST_REF_ROW: phase_len = REF_ROW_CYCLES;
            default: phase_len = PRECHARGE_CYCLES;
        endcase
    end

    assign phase_done = (phase_cnt_reg == phase_len - 3'h1);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (acc_go)
                    state_next = ST_ROW;
                else if (refresh_start)
                    state_next = ST_REF_ADDR;
            end
            ST_ROW: if (phase_done) state_next = ST_SELECT;
            ST_SELECT: if (phase_done) state_next = ST_COLUMN;
            ST_COLUMN: if (phase_done) state_next = ST_PRECHARGE;
            ST_REF_ADDR: if (phase_done) state_next = ST_REF_ROW;
            ST_REF_ROW: if (phase_done) state_next = ST_PRECHARGE;
            ST_PRECHARGE: if (phase_done) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            phase_cnt_reg <= 3'h0;
        end
        else
        begin
            state_reg <= state_next;
            phase_cnt_reg <= (state_next != state_reg) ? 3'h0 : phase_cnt_reg + 3'h1;
        end
    end

    assign delay_stage_one = (state_next == ST_SELECT) || (state_next == ST_COLUMN)
        || (state_next == ST_REF_ROW);
    assign delay_stage_two = (state_next == ST_COLUMN);

    // ==========================================================
    // Strobes, multiplexer and refresh flag
    // ==========================================================
    logic [3:0] ras_next;

    always_comb
    begin
        case (state_next)
            ST_ROW, ST_SELECT, ST_COLUMN: ras_next = bank_reg;
            ST_REF_ROW: ras_next = STROBES_ALL;
            default: ras_next = STROBES_NONE;
        endcase
    end

    // Strobes are registered so the array never sees decode glitches.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            row_strobe_n <= ~STROBES_NONE;
            col_strobe_n <= ~STROBES_NONE;
            row_col_sel <= 1'b0;
            refresh_cycle_flag <= 1'b0;
            mem_addr_lines <= 8'h00;
        end
        else
        begin
            row_strobe_n <= ~ras_next;
            col_strobe_n <= delay_stage_two ? ~bank_reg : ~STROBES_NONE;
            row_col_sel <= delay_stage_one && !refresh_busy_next(state_next);
            refresh_cycle_flag <= refresh_busy_next(state_next);
            if (refresh_busy_next(state_next))
                mem_addr_lines <= refresh_row_reg;
            else if (delay_stage_one)
                mem_addr_lines <= col_reg;
            else
                mem_addr_lines <= row_reg;
        end
    end

    function automatic logic refresh_busy_next(input seq_state_t st);
        refresh_busy_next = (st == ST_REF_ADDR) || (st == ST_REF_ROW);
    endfunction

    // ==========================================================
    // Ready, select and width answers
    // ==========================================================
    logic wait_reg;

    // The set wins; only an access that starts during a refresh waits, until its own column phase ends.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            wait_reg <= 1'b0;
        else if (cycle_start && hit && (s_read || s_write) && refresh_busy)
            wait_reg <= 1'b1;
        else if (access_done)
            wait_reg <= 1'b0;
    end

    assign rdy = !wait_reg;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            board_selected <= 1'b0;
            sixteen_ack <= 1'b0;
        end
        else
        begin
            board_selected <= hit;
            sixteen_ack <= hit && wide_live && wide_en;
        end
    end

    // ==========================================================
    // APB read side and counters
    // ==========================================================
    logic [15:0] refresh_count_reg;
    logic [15:0] access_count_reg;
    logic [31:0] status_word;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            refresh_count_reg <= 16'h0000;
            access_count_reg <= 16'h0000;
        end
        else
        begin
            if ((state_reg == ST_REF_ROW) && phase_done)
                refresh_count_reg <= refresh_count_reg + 16'h0001;
            if (access_done)
                access_count_reg <= access_count_reg + 16'h0001;
        end
    end

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[STAT_SELECTED_BIT] = board_selected;
        status_word[STAT_REFRESH_BIT] = refresh_cycle_flag;
        status_word[STAT_WAIT_BIT] = wait_reg;
        status_word[STAT_BUSY_BIT] = (state_reg != ST_IDLE);
        status_word[STAT_SIZE_LSB +: 2] = size;
        status_word[STAT_SWITCH_LSB +: 8] = s_switch;
    end

    // Read data is loaded in the setup cycle so the access phase needs no wait.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                CTRL_OFFSET: prdata <= ctrl_reg;
                STATUS_OFFSET: prdata <= status_word;
                COUNT_OFFSET: prdata <= {access_count_reg, refresh_count_reg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = apb_access && !is_mapped(paddr);

endmodule
`default_nettype wire

// [include/dram_card_pkg.sv]
package dram_card_pkg;

    // ==========================================================
    // Clock and refresh timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int REFRESH_INTERVAL_NS = 15000;
    localparam int REFRESH_INTERVAL_CYCLES = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int REFRESH_CNT_W = 11;
    localparam logic [REFRESH_CNT_W-1:0] REFRESH_LAST =
        REFRESH_CNT_W'(REFRESH_INTERVAL_CYCLES - 1);

    // ==========================================================
    // Delay-tap sequencer phase lengths, in core clock cycles
    // ==========================================================
    localparam logic [2:0] ROW_PHASE_CYCLES = 3'h2;
    localparam logic [2:0] SELECT_PHASE_CYCLES = 3'h1;
    localparam logic [2:0] COLUMN_PHASE_CYCLES = 3'h3;
    localparam logic [2:0] REF_ADDR_CYCLES = 3'h1;
    localparam logic [2:0] REF_ROW_CYCLES = 3'h3;
    localparam logic [2:0] PRECHARGE_CYCLES = 3'h2;

    // ==========================================================
    // Array size and board decode
    // ==========================================================
    typedef enum logic [1:0] {SIZE_256K, SIZE_128K, SIZE_64K} mem_size_t;
    localparam logic [4:0] DECODE_MASK_256K = 5'h0c;
    localparam logic [4:0] DECODE_MASK_128K = 5'h0e;
    localparam logic [4:0] DECODE_MASK_64K = 5'h0f;
    localparam logic [3:0] BANK_ZERO_ONLY = 4'h1;
    localparam logic [3:0] STROBES_ALL = 4'hf;
    localparam logic [3:0] STROBES_NONE = 4'h0;

    // ==========================================================
    // APB register map
    // ==========================================================
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] COUNT_OFFSET = 12'h008;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam int CTRL_REFRESH_EN_BIT = 0;
    localparam int CTRL_WIDE_EN_BIT = 1;
    localparam int STAT_SELECTED_BIT = 0;
    localparam int STAT_REFRESH_BIT = 1;
    localparam int STAT_WAIT_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_SIZE_LSB = 4;
    localparam int STAT_SWITCH_LSB = 8;
    localparam int COUNT_ACCESS_LSB = 16;

endpackage

// [design/dram_addr_select.sv]
`timescale 1ns/1ps
`default_nettype none
module dram_addr_select
    import dram_card_pkg::*;
(
    input wire logic [23:0] bus_addr,
    input wire logic [7:0] board_base_switch,
    input wire mem_size_t size,
    input wire logic bank_bit_jumper,
    input wire logic wide_access,
    output logic board_hit,
    output logic [7:0] row_addr,
    output logic [7:0] col_addr,
    output logic [3:0] bank_mask,
    output logic wide_ok
);

    function automatic logic [3:0] bank_onehot(input logic [1:0] idx);
        bank_onehot = 4'(4'h1 << idx);
    endfunction

    logic [4:0] sum;
    logic [4:0] mask;
    logic [3:0] rel;
    logic bank_hi;

    // The window starts at the lower switch value and wraps inside the megabyte block.
    assign sum = {1'b0, ~bus_addr[19:16]} + {1'b0, board_base_switch[3:0]};
    assign rel = bus_addr[19:16] - board_base_switch[3:0];

    always_comb
    begin
        case (size)
            SIZE_64K: mask = DECODE_MASK_64K;
            SIZE_128K: mask = DECODE_MASK_128K;
            default: mask = DECODE_MASK_256K;
        endcase
    end

    assign board_hit = (bus_addr[23:20] == board_base_switch[7:4])
        && ((sum & mask) == mask);
    assign row_addr = bus_addr[8:1];
    // With the bank bit jumper fitted, bit 0 replaces bit 16; one bank holds every byte only when size is SIZE_64K.
    assign col_addr = {bank_bit_jumper ? bus_addr[0] : bus_addr[16], bus_addr[15:9]};
    assign wide_ok = wide_access && (size != SIZE_64K);
    assign bank_hi = (size == SIZE_256K) && rel[1];

    always_comb
    begin
        if (size == SIZE_64K)
            bank_mask = BANK_ZERO_ONLY;
        else if (wide_ok)
            bank_mask = bank_onehot({bank_hi, 1'b0}) | bank_onehot({bank_hi, 1'b1});
        else
            bank_mask = bank_onehot({bank_hi, bus_addr[0]});
    end

endmodule
`default_nettype wire

// [verif/dram_card_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ========
// Strobe sequencing checks.
module dram_card_sva (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sixteen_ack,
    input wire logic [3:0] row_strobe_n,
    input wire logic [3:0] col_strobe_n,
    input wire logic row_col_sel,
    input wire logic refresh_cycle_flag
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    col_sel_a: assert property (col_strobe_n != 4'hf |-> row_col_sel)
        else $error("column strobe without select");
    sel_lead_a: assert property ($fell(&col_strobe_n) |-> $past(row_col_sel))
        else $error("select did not lead column strobe");
    cas_len_a: assert property ($fell(&col_strobe_n) |->
        (col_strobe_n != 4'hf)[*3] ##1 (col_strobe_n == 4'hf))
        else $error("column strobe length wrong");
    ref_no_cas_a: assert property (refresh_cycle_flag |-> col_strobe_n == 4'hf)
        else $error("column strobe in refresh");
    ref_all_ras_a: assert property (refresh_cycle_flag |-> row_strobe_n inside {4'h0, 4'hf})
        else $error("partial row strobe in refresh");
    ref_len_a: assert property ($rose(row_strobe_n == 4'h0) |->
        (row_strobe_n == 4'h0)[*3] ##1 (row_strobe_n == 4'hf))
        else $error("refresh row strobe length wrong");
    // A wide access strobes a bank pair, so only byte accesses are held to one bank.
    one_bank_a: assert property (!refresh_cycle_flag && !sixteen_ack |->
        $countones(~row_strobe_n) <= 1)
        else $error("more than one bank strobed");
    mux_row_a: assert property ($rose(&col_strobe_n) |-> ##[0:3] !row_col_sel)
        else $error("mux did not return to row");

    cover property ($rose(refresh_cycle_flag));
    cover property ($fell(&col_strobe_n));
    cover property (sixteen_ack && row_strobe_n == 4'hc);
endmodule

bind dram_card_addr_decode_strobe dram_card_sva i_dram_card_sva (.core_clk, .rstn,
    .sixteen_ack, .row_strobe_n, .col_strobe_n, .row_col_sel, .refresh_cycle_flag);
`default_nettype wire

// [verif/s100_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ========
// Bus master on the far side of the card.
module s100_master_model (
    input wire logic core_clk,
    input wire logic rdy,
    output logic [23:0] bus_addr,
    output logic mem_read_status,
    output logic mem_write_status,
    output logic psync,
    output logic pstval_n,
    output logic pwr_n,
    output logic sixteen_req
);
    initial
    begin
        bus_addr = 24'hffffff;
        {mem_read_status, mem_write_status, psync, sixteen_req} = 4'h0;
        {pstval_n, pwr_n} = 2'h3;
    end

    task automatic park(input logic [23:0] a);
        @(posedge core_clk);
        bus_addr <= a;
    endtask

    task automatic cycle(input logic [23:0] a, input logic wr, input logic wide);
        @(posedge core_clk);
        bus_addr <= a;
        {mem_read_status, mem_write_status, sixteen_req, psync} <= {!wr, wr, wide, 1'b1};
        @(posedge core_clk);
        pstval_n <= 1'b0;
        @(posedge core_clk);
        {psync, pstval_n, pwr_n} <= {1'b0, 1'b1, !wr};
        repeat (16) @(posedge core_clk);
        // Status stays up while ready is low, so a refresh stall stretches the cycle.
        while (rdy !== 1'b1)
            @(posedge core_clk);
        {mem_read_status, mem_write_status, sixteen_req, pwr_n} <= 4'h1;
        bus_addr <= ~a;
    endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ========
// Card bench.
module tb_top;
    logic core_clk, rstn, psel, penable, pwrite, size_jumper_a, size_jumper_b, bank_bit_jumper;
    logic pready, pslverr, mem_read_status, mem_write_status, psync, pstval_n, pwr_n, err;
    logic sixteen_req, board_selected, rdy, sixteen_ack, row_col_sel, refresh_cycle_flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] board_base_switch, mem_addr_lines;
    logic [23:0] bus_addr;
    logic [3:0] row_strobe_n, col_strobe_n;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;

    dram_card_addr_decode_strobe i_dram_card_addr_decode_strobe (.core_clk, .rstn, .paddr,
        .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .bus_addr,
        .mem_read_status, .mem_write_status, .psync, .pstval_n, .pwr_n, .sixteen_req,
        .board_base_switch, .size_jumper_a, .size_jumper_b, .bank_bit_jumper, .board_selected,
        .rdy, .sixteen_ack, .mem_addr_lines, .row_strobe_n, .col_strobe_n, .row_col_sel,
        .refresh_cycle_flag);
    s100_master_model i_s100_master_model (.core_clk, .rdy, .bus_addr, .mem_read_status,
        .mem_write_status, .psync, .pstval_n, .pwr_n, .sixteen_req);

    // ========
    // Shared tasks.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        {paddr, pwrite, pwdata, psel} <= {a, w, d, 1'b1};
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask

    task automatic straps(input int s, input logic [7:0] sw);
        @(posedge core_clk);
        {size_jumper_a, size_jumper_b, bank_bit_jumper} <= {s > 0, s == 2, s == 2};
        board_base_switch <= sw;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic wait_act(input logic col);
        int n = 0;
        do
            @(negedge core_clk);
        while ((col ? col_strobe_n : row_strobe_n) === 4'hf && ++n < 60);
        chk("strobe seen", 1'b1, n < 60);
    endtask

    task automatic wait_flag();
        while (refresh_cycle_flag === 1'b1) @(negedge core_clk);
        while (refresh_cycle_flag !== 1'b1) @(negedge core_clk);
    endtask

    // ========
    // Scenarios.
    task automatic test_regs();
        apb(12'h000, 1'b0, 32'h0);
        chk("ctrl reset", 32'h0000_0003, rd);
        apb(12'h000, 1'b1, 32'hffff_fffe);
        apb(12'h000, 1'b0, 32'h0);
        chk("ctrl bits", 32'h0000_0002, rd);
        apb(12'h00c, 1'b0, 32'h0);
        chk("unmapped err", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
    endtask

    task automatic test_decode();
        logic [3:0] rel;
        for (int s = 0; s < 3; s++)
        begin
            straps(s, 8'h5e);
            for (int i = 0; i < 32; i++)
            begin
                rel = i[3:0] - 4'he;
                i_s100_master_model.park({i[4] ? 4'h5 : 4'h4, i[3:0], 16'h8001});
                repeat (6) @(negedge core_clk);
                chk("selected", i[4] && rel < (4'h4 >> s), board_selected);
            end
        end
    endtask

    task automatic test_access();
        logic [23:0] at [5] = '{24'h03a5a4, 24'h025a5b, 24'h01c3c3, 24'h00ffff, 24'h00c3c3};
        int st [5] = '{0, 0, 1, 1, 2};
        int b;
        for (int k = 0; k < 5; k++)
        begin
            straps(st[k], 8'h00);
            b = st[k] == 2 ? 0 : st[k] == 1 ? at[k][0] : 2 * at[k][17] + at[k][0];
            fork
                i_s100_master_model.cycle(at[k], k[0], 1'b0);
                begin
                    wait_act(1'b0);
                    chk("row lines", at[k][8:1], mem_addr_lines);
                    chk("row strobe", 4'(~(4'h1 << b)), row_strobe_n);
                    wait_act(1'b1);
                    chk("col lines", {st[k] == 2 ? at[k][0] : at[k][16], at[k][15:9]}, mem_addr_lines);
                    chk("col select", 1'b1, row_col_sel);
                end
            join
        end
    endtask

    task automatic test_wide();
        for (int s = 1; s < 4; s++)
        begin
            if (s == 3)
                apb(12'h000, 1'b1, 32'h0);
            straps(s, 8'h00);
            fork
                i_s100_master_model.cycle(24'h000010, 1'b0, 1'b1);
                begin
                    wait_act(1'b0);
                    chk("wide ack", s == 1, sixteen_ack);
                    chk("wide strobe", s == 1 ? 4'hc : 4'he, row_strobe_n);
                end
            join
        end
    endtask

    task automatic test_refresh();
        int t0;
        logic [7:0] r0;
        apb(12'h000, 1'b1, 32'h3);
        wait_flag();
        t0 = cyc;
        r0 = mem_addr_lines;
        wait_act(1'b0);
        chk("ref rows", 4'h0, row_strobe_n);
        chk("ref cols", 4'hf, col_strobe_n);
        wait_flag();
        chk("ref interval", dram_card_pkg::REFRESH_INTERVAL_CYCLES, cyc - t0);
        chk("ref row", 8'(r0 + 8'h1), mem_addr_lines);
    endtask

    // Starts the cycle on the edge the next refresh begins, so the access must stall.
    task automatic test_contend();
        logic saw = 1'b0;
        repeat (1499) @(posedge core_clk);
        fork
            i_s100_master_model.cycle(24'h000100, 1'b0, 1'b0);
            repeat (30)
            begin
                @(negedge core_clk);
                saw |= (rdy === 1'b0);
            end
        join
        chk("wait seen", 1'b1, saw);
        chk("wait ends", 1'b1, rdy);
        apb(12'h008, 1'b0, 32'h0);
        chk("counts", 32'h0009_0003, rd);
        apb(12'h004, 1'b0, 32'h0);
        chk("status", 32'h0000_0010, rd);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) cyc++;

    initial
    begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        {size_jumper_a, size_jumper_b, bank_bit_jumper, board_base_switch} = '0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        test_regs();
        test_decode();
        test_access();
        test_wide();
        test_refresh();
        test_contend();
        tally_and_finish();
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
